// ---- verilog/msg_parser_pkg.sv ----
// Purpose: Shared constants and types for the control message parser
// Assumes: One byte per character, one character per valid beat
// Notes:   Command codes follow the control message set
package msg_parser_pkg;

  localparam int unsigned CHAR_W     = 8;
  localparam int unsigned CMD_LEN    = 7;
  localparam int unsigned EXT_LEN    = 3;
  localparam int unsigned FIFO_DEPTH = 8;

  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_SEMI  = 8'h3b;
  localparam logic [7:0] CH_UPPER_A = 8'h41;
  localparam logic [7:0] CH_UPPER_Z = 8'h5a;

  // Command words packed as 7 characters
  localparam logic [55:0] CMD_RECONF  = 56'h52_434f_4e46_4947;  // RCONFIG
  localparam logic [55:0] CMD_CONFDEF = 56'h43_4f4e_4644_4546;  // CONFDEF
  localparam logic [55:0] CMD_SUBCHAN = 56'h53_5542_4348_414e;
  localparam logic [55:0] CMD_USESTRM = 56'h55_5345_5354_524d;
  localparam logic [55:0] CMD_CMPNENT = 56'h43_4d50_4e45_4e54;
  localparam logic [55:0] CMD_SERVICE = 56'h53_4552_5649_4345;
  localparam logic [55:0] CMD_USEFIGF = 56'h55_5345_4649_4746;
  localparam logic [55:0] CMD_USERAPP = 56'h55_5345_5241_5050;
  localparam logic [55:0] CMD_FIGFILE = 56'h46_4947_4649_4c45;
  localparam logic [55:0] CMD_FIBGRID = 56'h46_4942_4752_4944;
  localparam logic [55:0] CMD_RESOURC = 56'h52_4553_4f55_5243;
  localparam logic [55:0] CMD_CHANCAP = 56'h43_4841_4e43_4150;
  localparam logic [55:0] CMD_CONNAME = 56'h43_4f4e_4e41_4d45;
  localparam logic [55:0] CMD_FIGNAME = 56'h46_4947_4e41_4d45;
  localparam logic [55:0] CMD_CONINFO = 56'h43_4f4e_494e_464f;

  localparam logic [23:0] EXT_DEF = 24'h44_4546;
  localparam logic [23:0] EXT_END = 24'h45_4e44;
  localparam logic [23:0] EXT_ERR = 24'h45_5252;
  localparam logic [23:0] EXT_REC = 24'h52_4543;
  localparam logic [23:0] EXT_INF = 24'h49_4e46;

  typedef enum logic [6:0] {
    SESS_NONE   = 7'b000_0001,
    SESS_CONFIG = 7'b000_0010,
    SESS_INFOGF = 7'b000_0100,
    SESS_GRID   = 7'b000_1000,
    SESS_RSRC   = 7'b001_0000,
    SESS_CFNAME = 7'b010_0000,
    SESS_IGNAME = 7'b100_0000
  } session_t;

  typedef enum logic [3:0] {
    ST_CMD  = 4'b0001,
    ST_EXT  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_SKIP = 4'b1000
  } parse_state_t;

  typedef enum logic [2:0] {
    ERR_NONE    = 3'h0,
    ERR_FORMAT  = 3'h1,
    ERR_UNKNOWN = 3'h2,
    ERR_CONTEXT = 3'h3,
    ERR_RANGE   = 3'h4,
    ERR_REMOTE  = 3'h5
  } err_code_t;

  typedef struct packed {
    logic [55:0] cmd;
    logic [23:0] command_extension;
    logic [7:0]  data_fields;
    session_t    session;
  } msg_info_t;

  typedef struct packed {
    logic [7:0] ch;
    logic       last;
  } char_beat_t;

endpackage : msg_parser_pkg

// ---- verilog/control_message_parser.sv ----
// Purpose: Parses the control message character stream, tracks sessions
// Assumes: Inputs synchronous to core_clk_in; one character per beat
// Notes:   Error replies are flagged on err_valid_out for a generator to send
// Summary of operation
// - Messages may arrive at any time; no frame schedule is assumed.
// - A message opens with the command word and ends at the terminator.
// - Command word and extension are mandatory; data fields are optional.
// - Command word is seven upper case letters.
// - One space separates adjacent fields.
// - Terminator is one semicolon character.
// - Data fields never hold space or semicolon.
// - Command and extension select the data field layout.
// - Decode the command word, then handle per extension.
// - Unknown command, bad format or range errors raise an error; no range check is made, and ERR_RANGE is never raised.
// - Session length is fixed or stated by the opening message.
// - Sender closes each session with an explicit close message.
// - Errors in or just after a session are reported by the recipient.
// - An error aborts, discards and implicitly closes the session.
// - Only one session may be open at a time.
// - Six session types are tracked.
// - Session-bound messages outside their session are flagged.
// - No action message inside an open configuration session.
// - Pairs from the wrong role may be rejected.
`timescale 1ns/100ps
module char_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_bad
    $error("DEPTH must be a power of two");
  end
  if (WIDTH < 1) begin : g_width_bad
    $error("WIDTH must be at least one");
  end

  // ----------------------------------------------------------------
  // Storage and flags
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  wire              full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                            (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire              empty = (wr_ptr_q == rd_ptr_q);
  wire              push  = wr_valid_in && !full;
  wire              pop   = rd_valid_out && rd_ready_in;
  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem_q[rd_ptr_q[AW-1:0]];

  // ----------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (push) mem_q[wr_ptr_q[AW-1:0]] <= wr_data_in;
  end

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
      if (pop) rd_ptr_q <= rd_ptr_q + (AW+1)'(1);
    end
  end
endmodule : char_fifo

module control_message_parser
  import msg_parser_pkg::*;
#(
  parameter int unsigned DEPTH     = FIFO_DEPTH,
  parameter bit          IS_UPSTREAM = 1'b0
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       char_valid_in,
  output logic            char_ready_out,
  input  wire logic [7:0] char_in,
  output logic            msg_valid_out,
  output msg_info_t       msg_info_out,
  output logic            err_valid_out,
  output err_code_t       err_code_out,
  output session_t        session_out,
  output logic            session_closed_out,
  output logic            session_abort_out
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_bad
    $error("DEPTH must be a power of two");
  end
  // The command and extension character counter is four bits wide
  if (CMD_LEN > 15 || EXT_LEN > 15) begin : g_len_bad
    $error("Field length exceeds the counter");
  end

  // ----------------------------------------------------------------
  // Input buffering
  // ----------------------------------------------------------------
  logic       fb_valid;
  char_beat_t wr_beat;
  char_beat_t rd_beat;
  assign wr_beat = '{ch: char_in, last: (char_in == CH_SEMI)};
  // characters taken whenever there is room
  char_fifo #(.WIDTH($bits(char_beat_t)), .DEPTH(DEPTH)) u_fifo (
    .core_clk_in  (core_clk_in),
    .rst_in       (rst_in),
    .wr_valid_in  (char_valid_in),
    .wr_ready_out (char_ready_out),
    .wr_data_in   (wr_beat),
    .rd_valid_out (fb_valid),
    .rd_ready_in  (1'b1),
    .rd_data_out  (rd_beat)
  );
  wire [7:0] ch       = rd_beat.ch;
  wire       is_sep   = (ch == CH_SPACE);
  wire       is_term  = rd_beat.last;
  wire       is_upper = (ch >= CH_UPPER_A) && (ch <= CH_UPPER_Z);

  // ----------------------------------------------------------------
  // Field scanner
  // ----------------------------------------------------------------
  parse_state_t st_q;
  logic [55:0]  cmd_q;
  logic [23:0]  ext_q;
  logic [3:0]   cnt_q;
  logic [7:0]   nfield_q;
  logic         dlen_q;
  logic         bad_q;

  wire cmd_full = (cnt_q == 4'(CMD_LEN));
  wire ext_full = (cnt_q == 4'(EXT_LEN));
  wire cmd_bad  = (st_q == ST_CMD) && ((is_upper && cmd_full) || (!is_upper && !is_sep) ||
                  (is_sep && !cmd_full));
  wire ext_bad  = (st_q == ST_EXT) && ((is_upper && ext_full) ||
                  (!is_upper && !is_sep && !is_term) ||
                  ((is_sep || is_term) && !ext_full));
  // empty data field means a separator followed by another separator or the terminator
  wire data_bad = (st_q == ST_DATA) && (is_sep || is_term) && !dlen_q;
  wire end_msg  = fb_valid && is_term;
  wire fmt_err  = bad_q || cmd_bad || ext_bad || data_bad || (st_q == ST_CMD) ||
                  ((st_q == ST_SKIP) && bad_q);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q     <= ST_CMD;
      cmd_q    <= '0;
      ext_q    <= '0;
      cnt_q    <= '0;
      nfield_q <= '0;
      dlen_q   <= 1'b0;
      bad_q    <= 1'b0;
    end else if (fb_valid) begin
      if (is_term) begin
        st_q     <= ST_CMD;
        cnt_q    <= '0;
        nfield_q <= '0;
        dlen_q   <= 1'b0;
        bad_q    <= 1'b0;
      end else begin
        unique case (st_q)
          ST_CMD: begin
            if (cmd_bad) begin
              st_q  <= ST_SKIP;
              bad_q <= 1'b1;
            end else if (is_sep) begin
              st_q  <= ST_EXT;
              cnt_q <= '0;
            end else begin
              cmd_q <= {cmd_q[47:0], ch};
              cnt_q <= cnt_q + 4'h1;
            end
          end
          ST_EXT: begin
            if (ext_bad) begin
              st_q  <= ST_SKIP;
              bad_q <= 1'b1;
            end else if (is_sep) begin
              st_q   <= ST_DATA;
              dlen_q <= 1'b0;
            end else begin
              ext_q <= {ext_q[15:0], ch};
              cnt_q <= cnt_q + 4'h1;
            end
          end
          // data fields split on space only
          ST_DATA: begin
            if (data_bad) begin
              st_q  <= ST_SKIP;
              bad_q <= 1'b1;
            end else if (is_sep) begin
              dlen_q <= 1'b0;
            end else begin
              if (!dlen_q) nfield_q <= nfield_q + 8'h01;
              dlen_q <= 1'b1;
            end
          end
          ST_SKIP: st_q <= ST_SKIP;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Command decode and session tracking
  // ----------------------------------------------------------------
  // decode command then extension
  wire c_cfg   = (cmd_q == CMD_CONFDEF);
  wire c_cfgm  = (cmd_q == CMD_SUBCHAN) || (cmd_q == CMD_USESTRM) ||
                 (cmd_q == CMD_CMPNENT) || (cmd_q == CMD_SERVICE) ||
                 (cmd_q == CMD_USEFIGF) || (cmd_q == CMD_USERAPP);
  wire c_fig   = (cmd_q == CMD_FIGFILE);
  wire c_grid  = (cmd_q == CMD_FIBGRID);
  wire c_rsrc  = (cmd_q == CMD_RESOURC);
  wire c_rsrcm = (cmd_q == CMD_CHANCAP);
  wire c_cfn   = (cmd_q == CMD_CONNAME);
  wire c_ign   = (cmd_q == CMD_FIGNAME);
  wire c_act   = (cmd_q == CMD_RECONF);
  wire known   = c_cfg | c_cfgm | c_fig | c_grid | c_rsrc | c_rsrcm | c_cfn | c_ign | c_act |
                 (cmd_q == CMD_CONINFO);
  wire e_def   = (ext_q == EXT_DEF);
  wire e_end   = (ext_q == EXT_END);
  wire e_err   = (ext_q == EXT_ERR);
  wire e_rec   = (ext_q == EXT_REC);
  wire sess_cmd = c_cfg | c_fig | c_grid | c_rsrc | c_cfn | c_ign;
  wire opener  = sess_cmd & e_def;
  // only a session command with END closes a session cleanly; any error aborts it
  wire closer  = sess_cmd & e_end;
  session_t sess_q;
  session_t sess_sel;
  assign sess_sel = c_cfg  ? SESS_CONFIG :
                    c_fig  ? SESS_INFOGF :
                    c_grid ? SESS_GRID   :
                    c_rsrc ? SESS_RSRC   :
                    c_cfn  ? SESS_CFNAME : SESS_IGNAME;
  wire in_sess = (sess_q != SESS_NONE);
  wire ctx_bad = (c_cfgm && sess_q != SESS_CONFIG) ||
                 (c_rsrcm && sess_q != SESS_RSRC) ||
                 (e_rec && ((c_fig && sess_q != SESS_INFOGF) ||
                            (c_grid && sess_q != SESS_GRID))) ||
                 (closer && (!in_sess || sess_q != sess_sel)) ||
                 (opener && in_sess) ||
                 (c_act && sess_q == SESS_CONFIG);
  // role check on grid and resource openers
  wire role_bad = IS_UPSTREAM ? 1'b0 : ((c_grid | c_rsrc) & e_def);
  err_code_t err_sel;
  assign err_sel = fmt_err          ? ERR_FORMAT  :
                   !known           ? ERR_UNKNOWN :
                   e_err            ? ERR_REMOTE  :
                   (ctx_bad | role_bad) ? ERR_CONTEXT : ERR_NONE;
  wire accept = end_msg && (err_sel == ERR_NONE);

  logic     abort_q;
  logic     close_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sess_q  <= SESS_NONE;
      abort_q <= 1'b0;
      close_q <= 1'b0;
    end else begin
      abort_q <= 1'b0;
      close_q <= 1'b0;
      if (end_msg) begin
        if (err_sel != ERR_NONE) begin
          abort_q <= in_sess;
          sess_q  <= SESS_NONE;
        end else if (closer) begin
          sess_q  <= SESS_NONE;
          close_q <= 1'b1;
        end else if (opener) begin
          sess_q <= sess_sel;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Result outputs
  // ----------------------------------------------------------------
  logic      mv_q;
  logic      ev_q;
  msg_info_t info_q;
  err_code_t ec_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mv_q   <= 1'b0;
      ev_q   <= 1'b0;
      info_q <= '{cmd: '0, command_extension: '0, data_fields: '0, session: SESS_NONE};
      ec_q   <= ERR_NONE;
    end else begin
      // pair and field count reported together
      mv_q <= accept;
      ev_q <= end_msg && (err_sel != ERR_NONE) && (err_sel != ERR_REMOTE);
      if (end_msg) begin
        info_q <= '{cmd: cmd_q, command_extension: ext_q, data_fields: nfield_q, session: sess_q};
        ec_q   <= err_sel;
      end
    end
  end
  assign msg_valid_out      = mv_q;
  assign msg_info_out       = info_q;
  assign err_valid_out      = ev_q;
  assign err_code_out       = ec_q;
  assign session_out        = sess_q;
  assign session_closed_out = close_q;
  assign session_abort_out  = abort_q;

endmodule : control_message_parser

// ---- dv/control_message_parser_properties.sv ----
// Purpose: Temporal checks on the parser ports
// Assumes: One clock, sync reset, two cycle terminator latency
// Notes:   Bound to every parser instance
`timescale 1ns/100ps
module parser_checker
  import msg_parser_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  input wire logic       char_valid_in,
  input wire logic       char_ready_out,
  input wire logic [7:0] char_in,
  input wire logic       msg_valid_out,
  input wire msg_info_t  msg_info_out,
  input wire logic       err_valid_out,
  input wire err_code_t  err_code_out,
  input wire session_t   session_out,
  input wire logic       session_closed_out,
  input wire logic       session_abort_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // --------------------------------
  // Sequences and properties
  // --------------------------------
  sequence s_term_taken;
    char_valid_in && char_ready_out && char_in == CH_SEMI;
  endsequence
  sequence s_answer;
    msg_valid_out || err_valid_out || err_code_out == ERR_REMOTE;
  endsequence
  property p_term_answers;
    s_term_taken |-> ##2 s_answer;
  endproperty
  property p_msg_cause;
    msg_valid_out |-> $past(char_in, 2) == CH_SEMI && $past(char_valid_in, 2);
  endproperty
  property p_err_cause;
    err_valid_out |-> $past(char_in, 2) == CH_SEMI;
  endproperty
  property p_excl;
    !(msg_valid_out && err_valid_out);
  endproperty
  property p_onehot;
    $onehot(session_out);
  endproperty
  property p_open;
    $changed(session_out) && session_out != SESS_NONE
      |-> $past(session_out) == SESS_NONE && msg_valid_out && msg_info_out.command_extension == EXT_DEF;
  endproperty
  property p_close;
    session_closed_out |-> session_out == SESS_NONE && $past(session_out) != SESS_NONE;
  endproperty
  property p_abort;
    session_abort_out |-> session_out == SESS_NONE && !msg_valid_out;
  endproperty
  property p_word;
    msg_valid_out |-> msg_info_out.cmd[55:48] inside {[CH_UPPER_A:CH_UPPER_Z]}
      && msg_info_out.command_extension[7:0] inside {[CH_UPPER_A:CH_UPPER_Z]};
  endproperty
  a_term_answers: assert property (p_term_answers) else $error("no answer");
  a_msg_cause: assert property (p_msg_cause) else $error("stray message");
  a_err_cause: assert property (p_err_cause) else $error("stray error");
  a_excl: assert property (p_excl) else $error("message and error");
  a_onehot: assert property (p_onehot) else $error("session not onehot");
  a_open: assert property (p_open) else $error("bad session open");
  a_close: assert property (p_close) else $error("bad close");
  a_abort: assert property (p_abort) else $error("bad abort");
  a_word: assert property (p_word) else $error("bad word");
endmodule : parser_checker

bind control_message_parser parser_checker parser_checker_inst (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .char_valid_in(char_valid_in),
  .char_ready_out(char_ready_out), .char_in(char_in), .msg_valid_out(msg_valid_out),
  .msg_info_out(msg_info_out), .err_valid_out(err_valid_out),
  .err_code_out(err_code_out), .session_out(session_out),
  .session_closed_out(session_closed_out), .session_abort_out(session_abort_out)
);

// ---- dv/remote_entity_model.sv ----
// Purpose: Far entity sending control messages character by character
// Assumes: Caller starts just after a rising edge
// Notes:   Character line scrambled while idle
`timescale 1ns/100ps
module remote_entity_model (
  input  wire logic       core_clk_in,
  input  wire logic       char_ready_in,
  output logic            char_valid_out,
  output logic      [7:0] char_out
);
  initial begin
    char_valid_out = 1'b0;
    char_out       = 8'h00;
  end
  task automatic send(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      char_valid_out <= 1'b1;
      char_out       <= s[i];
      n = 0;
      do begin
        @(posedge core_clk_in);
        n++;
      end while (char_ready_in !== 1'b1 && n < 20);
      if (n >= 20) begin
        tb.mismatches++;
        tb.wrap_up();
      end
    end
    char_valid_out <= 1'b0;
    char_out       <= ~char_out;
    @(posedge core_clk_in);
  endtask : send
endmodule : remote_entity_model

// ---- dv/tb.sv ----
// Purpose: Self-checking bench of the control message parser
// Assumes: Downstream instance, results two cycles after terminator
// Notes:   One task per scenario
`timescale 1ns/100ps
module tb
  import msg_parser_pkg::*;
;
  logic      core_clk_in, rst_in, char_valid_in, char_ready_out, msg_valid_out;
  logic      err_valid_out, session_closed_out, session_abort_out;
  logic [7:0] char_in;
  msg_info_t msg_info_out, info;
  err_code_t err_code_out, err_q;
  session_t  session_out, up_session;
  int        mismatches, checks, n_msg, n_err, n_cls, n_abt;

  control_message_parser control_message_parser_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .char_valid_in(char_valid_in),
    .char_ready_out(char_ready_out), .char_in(char_in), .msg_valid_out(msg_valid_out),
    .msg_info_out(msg_info_out), .err_valid_out(err_valid_out),
    .err_code_out(err_code_out), .session_out(session_out),
    .session_closed_out(session_closed_out), .session_abort_out(session_abort_out));
  remote_entity_model remote_entity_model_inst (
    .core_clk_in(core_clk_in), .char_ready_in(char_ready_out),
    .char_valid_out(char_valid_in), .char_out(char_in));
  control_message_parser #(.IS_UPSTREAM(1'b1)) control_message_parser_up_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .char_valid_in(char_valid_in),
    .char_ready_out(), .char_in(char_in), .msg_valid_out(), .msg_info_out(),
    .err_valid_out(), .err_code_out(), .session_out(up_session),
    .session_closed_out(), .session_abort_out());

  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    if (msg_valid_out === 1'b1) begin
      n_msg++;
      info = msg_info_out;
    end
    if (err_valid_out === 1'b1) begin
      n_err++;
      err_q = err_code_out;
    end
    if (session_closed_out === 1'b1) n_cls++;
    if (session_abort_out === 1'b1) n_abt++;
  end
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic probe(input string s, input int m, input int e, input session_t ses);
    n_msg = 0;
    n_err = 0;
    n_cls = 0;
    n_abt = 0;
    remote_entity_model_inst.send(s);
    repeat (3) @(posedge core_clk_in);
    check("messages", m, n_msg);
    check("errors", e, n_err);
    check("session", ses, session_out);
    check("ready", 1'b1, char_ready_out);
  endtask : probe
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic sc_config();
    probe("CONFDEF DEF;", 1, 0, SESS_CONFIG);
    check("cmd", CMD_CONFDEF, info.cmd);
    check("ext", EXT_DEF, info.command_extension);
    probe("SUBCHAN DEF A1 B22;", 1, 0, SESS_CONFIG);
    check("fields", 2, info.data_fields);
    check("in session", SESS_CONFIG, info.session);
    probe("RCONFIG INF;", 0, 1, SESS_NONE);
    check("abort", 1, n_abt);
  endtask : sc_config
  task automatic sc_format();
    string bad [6] = '{"CONFDE DEF;", "CONFDEf DEF;", "CONFDEF DE;",
                       "CONFDEF  DEF;", ";", "CONFDEF;"};
    foreach (bad[i]) begin
      probe(bad[i], 0, 1, SESS_NONE);
      check("format", ERR_FORMAT, err_q);
    end
    probe("CONINFO DEF  4;", 0, 1, SESS_NONE);
    check("empty field", ERR_FORMAT, err_q);
    probe("ABCDEFG DEF;", 0, 1, SESS_NONE);
    check("unknown", ERR_UNKNOWN, err_q);
  endtask : sc_format
  task automatic sc_context();
    probe("FIGFILE REC X1;", 0, 1, SESS_NONE);
    check("context", ERR_CONTEXT, err_q);
    probe("FIBGRID DEF;", 0, 1, SESS_NONE);
    check("role", ERR_CONTEXT, err_q);
    check("role up", SESS_GRID, up_session);
    probe("CONFDEF DEF;", 1, 0, SESS_CONFIG);
    probe("FIGFILE DEF;", 0, 1, SESS_NONE);
    check("second", ERR_CONTEXT, err_q);
  endtask : sc_context
  task automatic sc_abort();
    probe("FIGFILE DEF;", 1, 0, SESS_INFOGF);
    probe("FIGFILE REC X1;", 1, 0, SESS_INFOGF);
    probe("FIGFILE R;", 0, 1, SESS_NONE);
    check("abort", 1, n_abt);
    probe("FIGFILE END;", 0, 1, SESS_NONE);
    probe("CONFDEF DEF;", 1, 0, SESS_CONFIG);
    probe("CONFDEF ERR;", 0, 0, SESS_NONE);
    check("remote", ERR_REMOTE, err_code_out);
    check("abort", 1, n_abt);
  endtask : sc_abort
  task automatic sc_types();
    string    nm [4] = '{"CONFDEF", "FIGFILE", "CONNAME", "FIGNAME"};
    session_t st [4] = '{SESS_CONFIG, SESS_INFOGF, SESS_CFNAME, SESS_IGNAME};
    for (int i = 0; i < 4; i++) begin
      probe({nm[i], " DEF;"}, 1, 0, st[i]);
      probe({nm[i], " END;"}, 1, 0, SESS_NONE);
      check("closed", 1, n_cls);
    end
  endtask : sc_types
  task automatic sc_back();
    probe("CONINFO INF;CONINFO DEF 4 2;", 2, 0, SESS_NONE);
    check("fields", 2, info.data_fields);
    check("cmd", CMD_CONINFO, info.cmd);
    probe("CONINFO END;", 1, 0, SESS_NONE);
    check("no close", 0, n_cls);
  endtask : sc_back

  initial begin
    mismatches = 0;
    checks     = 0;
    rst_in     = 1'b1;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    sc_config();
    sc_format();
    sc_context();
    sc_abort();
    sc_types();
    sc_back();
    wrap_up();
  end
endmodule : tb
